// file: verilog/bus_ack_pkg.sv
/*
 * package for the bus cycle acknowledge block: widths, pin levels,
 * sampler depth and the packed carriers for the slave and master sides.
 * assumes one 100 MHz clock and active-low acknowledge pins.
 */
package bus_ack_pkg;
    localparam int          DATA_W         = 32;
    localparam int          REG_W          = 16;
    localparam logic        ACK_ASSERTED   = 1'b0;  // pins are active low
    localparam logic        ACK_RELEASED   = 1'b1;
    localparam logic        OE_DRIVE       = 1'b0;  // output enable low while driving
    localparam logic        OE_FLOAT       = 1'b1;
    localparam logic        MODE_ACK_STYLE = 1'b1;  // bus style that uses the ack pins
    localparam int          SYNC_STAGES    = 2;
    localparam logic [15:0] UPPER_FILL     = 16'h0000; // meaningless upper half

    // register access that is finishing this cycle
    typedef struct packed {
        logic              done;   // one-cycle completion pulse
        logic [REG_W-1:0]  rdata;  // register read data
        logic              is_read;
    } slave_done_t;

    // master cycle request from the dma engine
    typedef struct packed {
        logic start;    // one-cycle start pulse
        logic sync_sel; // sync_sampling_select of the configuration
        logic wide;     // static bus size: 1 = 32-bit, 0 = 16-bit
    } master_req_t;
endpackage

// file: verilog/ack_sampler.sv
/*
 * ack_sampler: takes one acknowledge pin either straight (synchronous bus)
 * or through a two flop synchroniser (asynchronous bus).
 * assumes the select is steady while a master cycle runs.
 */
`timescale 1ns/1ns
module ack_sampler
    import bus_ack_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    input  wire logic i_sync_sel,
    output logic      o_level
);
    logic [STAGES-1:0] sync_q;

    // ================================================================
    // synchroniser chain; first flop is read only by the next flop
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync_q <= {STAGES{ACK_RELEASED}};
        end else begin
            sync_q <= {sync_q[STAGES-2:0], i_pin};
        end
    end

    // synchronous bus saves the latency; async bus needs the chain
    assign o_level = i_sync_sel ? i_pin : sync_q[STAGES-1];
endmodule // ack_sampler

// file: verilog/bus_cycle_acknowledge.sv
/*
 * bus_cycle_acknowledge: drives the two data/size acknowledge pins to end
 * register accesses and samples them to end the device's own master cycles.
 * assumes register logic gives a completion pulse and the dma engine a
 * start pulse; bus size and sampling style are static configuration bits.
 */
`timescale 1ns/1ns
module bus_cycle_acknowledge
    import bus_ack_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_bus_style_select,
    input  wire slave_done_t       i_slave,
    input  wire master_req_t       i_master,
    input  wire logic              i_ack_pin_lower,
    input  wire logic              i_ack_pin_upper,
    output logic                   o_ack_pin_lower,
    output logic                   o_ack_pin_upper,
    output logic                   o_ack_oe_n,
    output logic [DATA_W-1:0]      o_data,
    output logic                   o_data_oe_n,
    output logic                   o_master_busy,
    output logic                   o_master_done,
    output logic                   o_wait_state
);
    typedef enum logic [0:0] {M_IDLE, M_ACTIVE} mstate_t;

    mstate_t state_q;
    logic    wide_q;
    logic    sync_q;
    logic    lower_lvl;
    logic    upper_lvl;
    logic    acked;
    logic    style_ok;

    // reset defaults of the latched configuration: a 32-bit synchronous
    // bus until the first master cycle says otherwise
    localparam logic WIDE_AT_RESET = 1'b1;
    localparam logic SYNC_AT_RESET = 1'b1;

    // on an asynchronous bus the chain still carries pin samples taken
    // before a cycle starts; that many sampled edges are skipped
    localparam int                 BLANK_W    = $clog2(SYNC_STAGES + 1);
    localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(SYNC_STAGES);

    logic [BLANK_W-1:0] blank_q;

    assign style_ok = (i_bus_style_select == MODE_ACK_STYLE);

    // ================================================================
    // acknowledge sampling, one sampler per pin
    ack_sampler #(.STAGES(SYNC_STAGES)) u_samp_lower (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_pin      (i_ack_pin_lower),
        .i_sync_sel (sync_q),
        .o_level    (lower_lvl)
    );
    ack_sampler #(.STAGES(SYNC_STAGES)) u_samp_upper (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_pin      (i_ack_pin_upper),
        .i_sync_sel (sync_q),
        .o_level    (upper_lvl)
    );

    // end condition depends only on the latched width, never the pattern;
    // nothing counts while the blanking counter still runs
    always_comb begin
        if (blank_q != '0) begin
            acked = 1'b0;
        end else if (wide_q) begin
            acked = (lower_lvl == ACK_ASSERTED) && (upper_lvl == ACK_ASSERTED);
        end else begin
            acked = (upper_lvl == ACK_ASSERTED);
        end
    end

    // ================================================================
    // slave termination: one-cycle drive of both pins and read data
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_ack_pin_lower <= ACK_RELEASED;
            o_ack_pin_upper <= ACK_RELEASED;
            o_ack_oe_n      <= OE_FLOAT;
        end else if (i_slave.done && style_ok) begin
            o_ack_pin_lower <= ACK_ASSERTED;
            o_ack_pin_upper <= ACK_ASSERTED;
            o_ack_oe_n      <= OE_DRIVE;
        end else begin
            o_ack_pin_lower <= ACK_RELEASED;
            o_ack_pin_upper <= ACK_RELEASED;
            o_ack_oe_n      <= OE_FLOAT;
        end
    end

    // read data on the low half; the upper half is driven with filler
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_data      <= '0;
            o_data_oe_n <= OE_FLOAT;
        end else if (i_slave.done && i_slave.is_read && style_ok) begin
            o_data      <= {UPPER_FILL, i_slave.rdata};
            o_data_oe_n <= OE_DRIVE;
        end else begin
            o_data_oe_n <= OE_FLOAT;
        end
    end

    // ================================================================
    // master cycle: configuration latched at start and held to the end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q       <= M_IDLE;
            wide_q        <= WIDE_AT_RESET;
            sync_q        <= SYNC_AT_RESET;
            o_master_busy <= 1'b0;
            o_master_done <= 1'b0;
            o_wait_state  <= 1'b0;
        end else begin
            o_master_done <= 1'b0;
            unique case (state_q)
                M_IDLE: begin
                    o_wait_state <= 1'b0;
                    if (i_master.start && style_ok) begin
                        state_q       <= M_ACTIVE;
                        wide_q        <= i_master.wide;
                        sync_q        <= i_master.sync_sel;
                        o_master_busy <= 1'b1;
                    end
                end
                M_ACTIVE: begin
                    if (acked) begin
                        state_q       <= M_IDLE;
                        o_master_busy <= 1'b0;
                        o_master_done <= 1'b1;
                        o_wait_state  <= 1'b0;
                    end else begin
                        o_wait_state  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ================================================================
    // stale acknowledge blanking
    // the previous responder may still hold its ack for an edge or two
    // after the done pulse; on an asynchronous bus those late samples
    // sit in the synchroniser and would end the next cycle at once.
    // costs nothing on a synchronous bus, where the load is zero.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            blank_q <= '0;
        end else if (state_q == M_IDLE && i_master.start && style_ok) begin
            blank_q <= i_master.sync_sel ? '0 : BLANK_LOAD;
        end else if (blank_q != '0) begin
            blank_q <= blank_q - 1'b1;
        end
    end

    // ================================================================
    // checks
    // one property per rule; the tag closes the label's line

    // slave side
    a_slave_both_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_slave.done && style_ok) |=> (!o_ack_pin_lower && !o_ack_pin_upper && !o_ack_oe_n))
        else $error("slave ack not driven on both pins");
    a_ack_pair_equal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_ack_pin_lower == o_ack_pin_upper)
        else $error("ack pins driven apart");
    a_read_low_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_slave.done && i_slave.is_read && style_ok)
        |=> (o_data[REG_W-1:0] == $past(i_slave.rdata)) && !o_data_oe_n)
        else $error("read data not on low lines");
    a_style_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !style_ok |=> o_ack_oe_n)
        else $error("ack driven outside ack bus style");

    // master side
    a_master_wide_end: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_ACTIVE && wide_q && !(lower_lvl == ACK_ASSERTED
         && upper_lvl == ACK_ASSERTED)) |=> !o_master_done)
        else $error("32-bit cycle ended without both acks");
    a_master_narrow_end: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_ACTIVE && !wide_q && blank_q == '0 && upper_lvl == ACK_ASSERTED)
        |=> o_master_done)
        else $error("16-bit cycle missed upper ack");
    a_master_waits: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_ACTIVE && !acked) |=> (o_master_busy && o_wait_state))
        else $error("cycle dropped without ack");
    a_width_static: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_ACTIVE && $past(state_q) == M_ACTIVE) |-> $stable(wide_q))
        else $error("width changed within a cycle");
    a_done_after_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_master_done |-> $past(acked) && $past(state_q == M_ACTIVE))
        else $error("cycle ended without sampled ack");

    // refusals, pulse shapes and blanking
    a_start_refused: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_IDLE && i_master.start && !style_ok) |=> !o_master_busy)
        else $error("master cycle started outside ack bus style");
    a_stale_ack_blank: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_q == M_ACTIVE && blank_q != '0) |=> !o_master_done)
        else $error("cycle ended on a sample older than its start");
    a_done_one_cycle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_master_done |=> !o_master_done)
        else $error("done pulse longer than one cycle");
    a_data_drive_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(i_slave.done && i_slave.is_read && style_ok) |=> o_data_oe_n)
        else $error("data lines driven without a finishing read");
endmodule // bus_cycle_acknowledge

// file: tb/mem_responder.sv
/*
 * mem_responder: memory that answers the device's own master cycles on
 * the two acknowledge pins after a set number of busy cycles.
 * assumes pull-ups on both pins, so a released pin reads high.
 */
`timescale 1ns/1ns
module mem_responder
    import bus_ack_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_busy,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_both,
    output logic            o_lower,
    output logic            o_upper
);
    logic [3:0] wait_q;

    // ==========================================================
    // answer
    // count busy cycles, then hold the ack until the cycle ends
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_busy) begin
            wait_q  <= 4'h0;
            o_lower <= ACK_RELEASED; // pull-up takes over
            o_upper <= ACK_RELEASED;
        end else if (wait_q != i_delay) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            o_upper <= ACK_ASSERTED; // enough for a 16-bit port
            o_lower <= i_both ? ACK_ASSERTED : ACK_RELEASED; // 32-bit needs both
        end
    end
endmodule // mem_responder

// file: tb/test_bus_cycle_acknowledge.sv
/*
 * test_bus_cycle_acknowledge: self-checking bench for slave and master
 * acknowledge handling.
 * assumes the responder model on the far side and pull-ups on the pins.
 */
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_bus_cycle_acknowledge
    import bus_ack_pkg::*;
;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_bus_style_select = 1'b1;
    slave_done_t i_slave = '0;
    master_req_t i_master = '0;
    logic ack_lo, ack_up, pin_lo, pin_up, ack_oe_n, data_oe_n;
    logic busy, done, wait_st, rsp_lo, rsp_up, rsp_both = 1'b1;
    logic [3:0] rsp_delay = 4'h0;
    logic [DATA_W-1:0] data;
    int errors = 0, check_count = 0, cyc = 0, lat_s, lat_a;

    always #5 i_clk = ~i_clk;
    // both parties only pull low, so the wire is the and of them
    assign pin_lo = ((ack_oe_n == OE_DRIVE) ? ack_lo : ACK_RELEASED) & rsp_lo;
    assign pin_up = ((ack_oe_n == OE_DRIVE) ? ack_up : ACK_RELEASED) & rsp_up;

    bus_cycle_acknowledge bus_cycle_acknowledge_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_bus_style_select(i_bus_style_select), .i_slave(i_slave), .i_master(i_master),
        .i_ack_pin_lower(pin_lo), .i_ack_pin_upper(pin_up), .o_ack_pin_lower(ack_lo),
        .o_ack_pin_upper(ack_up), .o_ack_oe_n(ack_oe_n), .o_data(data),
        .o_data_oe_n(data_oe_n), .o_master_busy(busy), .o_master_done(done),
        .o_wait_state(wait_st));
    mem_responder mem_responder_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_busy(busy),
        .i_delay(rsp_delay), .i_both(rsp_both), .o_lower(rsp_lo), .o_upper(rsp_up));

    // ==========================================================
    // closing
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hang guard: the whole run needs well under 1000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // scenarios
    // answer stands for the one cycle after the edge that takes done
    task automatic slave_access(input logic style, input logic rd, input logic [15:0] v);
        i_bus_style_select <= style;
        i_slave <= '{1'b1, v, rd};
        @(posedge i_clk) i_slave <= '0;
        #1;
        `CHK("ack oe", style ? OE_DRIVE : OE_FLOAT, ack_oe_n)
        `CHK("ack pins", style ? 2'b00 : 2'b11, {pin_lo, pin_up})
        `CHK("data oe", (style && rd) ? OE_DRIVE : OE_FLOAT, data_oe_n)
        if (style && rd) `CHK("read data", v, data[REG_W-1:0])
        @(posedge i_clk) #1;
        `CHK("ack release", OE_FLOAT, ack_oe_n)
        `CHK("data release", OE_FLOAT, data_oe_n)
        @(posedge i_clk);
    endtask

    // a start outside the ack bus style must not open a cycle
    task automatic master_refused();
        i_bus_style_select <= 1'b0;
        i_master <= '{1'b1, 1'b1, 1'b1};
        @(posedge i_clk) i_master <= '0;
        @(posedge i_clk) #1;
        `CHK("start refused", 1'b0, busy)
        `CHK("no wait when refused", 1'b0, wait_st)
        @(posedge i_clk);
    endtask

    // start a master cycle, then wait at most 39 cycles for its end
    task automatic run_master(input logic wide, sync, both, output int lat);
        i_bus_style_select <= 1'b1;
        rsp_both <= both;
        i_master <= '{1'b1, sync, wide};
        @(posedge i_clk) i_master <= '0;
        for (lat = 1; lat < 40; lat++) begin
            @(posedge i_clk) #1;
            if (done === 1'b1) break;
            if (lat == 10 && !both) begin
                `CHK("no end on upper only", 1'b1, busy)
                `CHK("wait state", 1'b1, wait_st)
                rsp_both <= 1'b1;
            end
        end
        `CHK("cycle ended", 1'b1, done)
        `CHK("wait cleared", 1'b0, wait_st)
        @(posedge i_clk);
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        slave_access(1'b1, 1'b1, 16'ha5c3);
        slave_access(1'b1, 1'b0, 16'h1234);
        slave_access(1'b0, 1'b1, 16'h5a3c);
        master_refused();
        run_master(1'b1, 1'b1, 1'b0, lat_s);
        rsp_delay <= 4'h2;
        run_master(1'b0, 1'b1, 1'b0, lat_s);
        // upper ack at the pin after the third busy edge, done one edge later
        `CHK("16-bit latency", 4, lat_s)
        run_master(1'b0, 1'b0, 1'b0, lat_a);
        `CHK("async extra", lat_s + 2, lat_a)
        tally_and_finish();
    end
endmodule // test_bus_cycle_acknowledge
